/* File: lbp_backlight.sv */
// Purpose: Backlight LED PWM and boost control with a Wishbone register file.
// Assumes: Fault detector inputs are synchronous to clk_i and high while active.
// Notes: Register byte address is four times the register index; data in bits 7:0.
//
// Overview of operation
// - Each PWM waveform repeats every 95 steps of the 2 MHz step clock.
// - Current mode duty is 0 or spans 16 to 95 of the 95 steps of the period.
// - A ratio above 95 holds the string switch permanently on.
// - Active part uses the string code; idle part uses the shared code.
// - With dimming set, ratio moves one step every 40 ms to target.
// - With dimming clear, a new ratio applies from the next period start.
// - Each string takes an 8-bit logarithmic current code, 256 steps.
// - With ramp set, code moves one step per 1 ms per string.
// - Boost turns itself off on over-voltage or over-current.
// - Boost fault sets read-only event flag in boost bit 7.
// - Boost bit 6 masks the fault from the active-low interrupt.
// - Boost bit 5 selects 1 MHz or 2 MHz switching.
// - Boost bit 4 selects 710 mA or 1000 mA inductor limit.
// - Boost bits 1 to 3 include each string in loop regulation.
// - String three PWM-only mode drops loop inclusion, allows 0 to 100 percent.
// - Clearing a sink enable clears its loop inclusion bit.
`timescale 1ns/100ps
`default_nettype none
module lbp_backlight #(
   parameter int DIM_CYCLES = lbp_pkg::DIM_CYCLES,
   parameter int RAMP_CYCLES = lbp_pkg::RAMP_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [lbp_pkg::ADR_W-1:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   input wire logic over_voltage_i,
   input wire logic over_current_i,
   output logic interrupt_out_n_o,
   output logic boost_enable_o,
   output logic string1_loop_include_o,
   output logic string2_loop_include_o,
   output logic string3_loop_include_o,
   output logic inductor_limit_select_o,
   output logic switching_rate_select_o,
   output logic current_drive_mode_o,
   output logic sink1_enable_o,
   output logic sink2_enable_o,
   output logic sink3_enable_o,
   output logic [2:0] string_switch_o,
   output logic [7:0] log_current_code1_o,
   output logic [7:0] log_current_code2_o,
   output logic [7:0] log_current_code3_o
);
   localparam int N = lbp_pkg::STRINGS;

   lbp_timing_if tm();

   logic [7:0] idx;
   logic req;
   logic wr;
   logic rd_boost;
   logic [7:0] rdata;
   logic [6:0] boost;
   logic [6:0] next_boost;
   logic fault_flag;
   logic fault_evt;
   logic [7:0] sink_ctrl;
   logic [7:0] next_sink;
   logic [7:0] shared_idle_current;
   logic [7:0] idle_app;
   logic [7:0] code_tgt [N];
   logic [7:0] pwm_ctrl [N];
   logic [6:0] ratio_app [N];
   logic [7:0] code_app [N];
   logic [7:0] code_q [N];
   logic [N-1:0] sink_en;
   logic [N-1:0] drive_en;
   logic [N-1:0] sw_q;
   logic pwm_only;

   assign idx = adr_i[9:2];
   assign req = cyc_i && stb_i && !ack_o;
   assign wr = req && we_i && sel_i[0];
   assign rd_boost = req && !we_i && (idx == lbp_pkg::REG_BOOST);
   assign pwm_only = !sink_ctrl[lbp_pkg::MODE3_BIT];

   lbp_tick #(
      .DIM_CYCLES(DIM_CYCLES),
      .RAMP_CYCLES(RAMP_CYCLES)
   ) u_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tm(tm)
   );

   // Wishbone answer one cycle after the request is seen.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= req;
         if (req) begin
            dat_o <= {24'h000000, rdata};
         end
      end
   end

   always_comb begin
      rdata = 8'h00;
      case (idx)
         lbp_pkg::REG_BOOST: rdata = {fault_flag, boost};
         lbp_pkg::REG_SINK_CTRL: rdata = sink_ctrl;
         lbp_pkg::REG_IDLE_CODE: rdata = shared_idle_current;
         default: rdata = 8'h00;
      endcase
      for (int k = 0; k < N; k++) begin
         if (idx == lbp_pkg::REG_CODE_BASE + 8'(k)) begin
            rdata = code_tgt[k];
         end
         if (idx == lbp_pkg::REG_PWM_BASE + 8'(k)) begin
            rdata = pwm_ctrl[k];
         end
      end
   end

   always_comb begin
      next_sink = sink_ctrl;
      if (wr && idx == lbp_pkg::REG_SINK_CTRL) begin
         next_sink = dat_i[7:0];
      end
      if (!next_sink[lbp_pkg::MODE3_BIT]) begin
         next_sink[lbp_pkg::SINK_EN_LSB + 2 * (N - 1)] = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sink_ctrl <= lbp_pkg::SINK_CTRL_RST;
      end else begin
         sink_ctrl <= next_sink;
      end
   end

   assign fault_evt = (over_voltage_i || over_current_i) && boost[lbp_pkg::BOOST_EN_BIT];

   always_comb begin
      next_boost = boost;
      if (wr && idx == lbp_pkg::REG_BOOST) begin
         next_boost = dat_i[6:0];
      end
      for (int k = 0; k < N; k++) begin
         next_boost[lbp_pkg::INCLUDE_LSB + k] = next_boost[lbp_pkg::INCLUDE_LSB + k]
            && next_sink[lbp_pkg::SINK_EN_LSB + 2 * k];
      end
      if (fault_evt) begin
         next_boost[lbp_pkg::BOOST_EN_BIT] = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         boost <= lbp_pkg::BOOST_RST;
      end else begin
         boost <= next_boost;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_flag <= 1'b0;
      end else if (fault_evt) begin
         fault_flag <= 1'b1;
      end else if (rd_boost) begin
         fault_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         interrupt_out_n_o <= 1'b1;
      end else begin
         interrupt_out_n_o <= !(fault_flag && !boost[lbp_pkg::MASK_BIT]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shared_idle_current <= lbp_pkg::CODE_RST;
         idle_app <= lbp_pkg::CODE_RST;
      end else begin
         if (wr && idx == lbp_pkg::REG_IDLE_CODE) begin
            shared_idle_current <= dat_i[7:0];
         end
         if (tm.wrap) begin
            idle_app <= shared_idle_current;
         end
      end
   end

   assign boost_enable_o = boost[lbp_pkg::BOOST_EN_BIT];
   assign string1_loop_include_o = boost[lbp_pkg::INCLUDE_LSB];
   assign string2_loop_include_o = boost[lbp_pkg::INCLUDE_LSB + 1];
   assign string3_loop_include_o = boost[lbp_pkg::INCLUDE_LSB + 2];
   assign inductor_limit_select_o = boost[lbp_pkg::ILIM_BIT];
   assign switching_rate_select_o = boost[lbp_pkg::FRQ_BIT];
   assign current_drive_mode_o = sink_ctrl[lbp_pkg::DRIVE_MODE_BIT];
   assign sink1_enable_o = sink_ctrl[lbp_pkg::SINK_EN_LSB];
   assign sink2_enable_o = sink_ctrl[lbp_pkg::SINK_EN_LSB + 2];
   assign sink3_enable_o = sink_ctrl[lbp_pkg::SINK_EN_LSB + 4];
   assign string_switch_o = sw_q;
   assign log_current_code1_o = code_q[0];
   assign log_current_code2_o = code_q[1];
   assign log_current_code3_o = code_q[2];

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   for (genvar i = 0; i < N; i++) begin : g_str
      localparam bit IS_LAST = (i == N - 1);
      logic sw_next;

      assign sink_en[i] = sink_ctrl[lbp_pkg::SINK_EN_LSB + 2 * i];
      assign drive_en[i] = sink_en[i] || (IS_LAST && pwm_only);

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            code_tgt[i] <= lbp_pkg::CODE_RST;
            pwm_ctrl[i] <= lbp_pkg::PWM_RST;
         end else begin
            if (wr && idx == lbp_pkg::REG_CODE_BASE + 8'(i)) begin
               code_tgt[i] <= dat_i[7:0];
            end
            if (wr && idx == lbp_pkg::REG_PWM_BASE + 8'(i)) begin
               pwm_ctrl[i] <= dat_i[7:0];
            end
         end
      end

      lbp_string u_str (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .tm(tm),
         .ratio_tgt_i(pwm_ctrl[i][6:0]),
         .dim_i(pwm_ctrl[i][lbp_pkg::DIM_BIT]),
         .code_tgt_i(code_tgt[i]),
         .ramp_i(sink_ctrl[lbp_pkg::SINK_RAMP_LSB + 2 * i]),
         .pwm_only_i(IS_LAST && pwm_only),
         .ratio_o(ratio_app[i]),
         .code_o(code_app[i])
      );

      assign sw_next = drive_en[i] && (tm.phase < ratio_app[i]);

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            sw_q[i] <= 1'b0;
            code_q[i] <= 8'h00;
         end else begin
            sw_q[i] <= sw_next;
            code_q[i] <= !drive_en[i] ? 8'h00 : (sw_next ? code_app[i] : idle_app);
         end
      end

      a_full_duty: assert property (drive_en[i] && ratio_app[i] > lbp_pkg::PWM_STEPS |=> sw_q[i])
         else $error("Switch not held on above full ratio");
      a_high_code: assert property (sw_q[i] |-> code_q[i] == $past(code_app[i]))
         else $error("Active code not the string code");
      a_idle_code: assert property (!sw_q[i] && $past(drive_en[i]) |-> code_q[i] == $past(idle_app))
         else $error("Idle code not the shared code");
      a_include_drop: assert property (!sink_en[i] |-> !boost[lbp_pkg::INCLUDE_LSB + i])
         else $error("Loop inclusion kept with sink disabled");
   end

   a_fault_off: assert property (fault_evt |=> !boost_enable_o && fault_flag)
      else $error("Boost not shut down on fault");
   a_irq_cause: assert property (!interrupt_out_n_o |-> $past(fault_flag && !boost[lbp_pkg::MASK_BIT]))
      else $error("Interrupt without unmasked fault");
   a_irq_raise: assert property (fault_flag && !boost[lbp_pkg::MASK_BIT] |=> !interrupt_out_n_o)
      else $error("Unmasked fault did not interrupt");
   a_pwm_only: assert property (pwm_only |-> !sink3_enable_o && !string3_loop_include_o)
      else $error("PWM-only string still regulated");
   c_fault: cover property (fault_evt ##1 !interrupt_out_n_o);
   c_full_on: cover property (sw_q[0] [*8]);
   c_pwm_only: cover property (pwm_only && sw_q[2]);
endmodule
`default_nettype wire

/* File: lbp_pkg.sv */
// Purpose: Shared constants for the LED backlight PWM control block.
// Assumes: 20 MHz system clock, 32-bit classic Wishbone with word-spaced registers.
// Notes: Register indices are multiplied by four to form byte addresses.
package lbp_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int STEP_HZ = 2000000;
   localparam int STEP_DIV = CLK_HZ / STEP_HZ;
   localparam int PWM_PERIOD_STEPS = 95;
   localparam int PERIOD_CYCLES = STEP_DIV * PWM_PERIOD_STEPS;
   localparam int DIM_STEP_MS = 40;
   localparam int RAMP_STEP_MS = 1;
   localparam int DIM_CYCLES = CLK_HZ / 1000 * DIM_STEP_MS;
   localparam int RAMP_CYCLES = CLK_HZ / 1000 * RAMP_STEP_MS;
   localparam int TICK_W = 20;
   localparam int DIV_W = 4;
   localparam int STRINGS = 3;
   localparam int ADR_W = 10;

   localparam logic [6:0] PWM_STEPS = 7'(PWM_PERIOD_STEPS);
   localparam logic [6:0] PWM_LAST = 7'(PWM_PERIOD_STEPS - 1);
   localparam logic [6:0] PWM_MIN_RATIO = 7'h10;

   localparam logic [7:0] REG_BOOST = 8'h46;
   localparam logic [7:0] REG_SINK_CTRL = 8'h47;
   localparam logic [7:0] REG_IDLE_CODE = 8'h48;
   localparam logic [7:0] REG_CODE_BASE = 8'h49;
   localparam logic [7:0] REG_PWM_BASE = 8'h4C;

   localparam int BOOST_EN_BIT = 0;
   localparam int INCLUDE_LSB = 1;
   localparam int ILIM_BIT = 4;
   localparam int FRQ_BIT = 5;
   localparam int MASK_BIT = 6;
   localparam int SINK_EN_LSB = 0;
   localparam int SINK_RAMP_LSB = 1;
   localparam int MODE3_BIT = 6;
   localparam int DRIVE_MODE_BIT = 7;
   localparam int DIM_BIT = 7;

   localparam logic [6:0] BOOST_RST = 7'h00;
   localparam logic [7:0] SINK_CTRL_RST = 8'h00;
   localparam logic [7:0] CODE_RST = 8'h00;
   localparam logic [7:0] PWM_RST = 8'h00;
endpackage

/* File: lbp_timing_if.sv */
// Purpose: Carries the step, period and slow-rate enables to each string.
// Assumes: All signals are one-cycle pulses on clk_i except phase.
// Notes: Phase counts PWM steps within one period.
`timescale 1ns/100ps
`default_nettype none
interface lbp_timing_if;
   logic step_en;
   logic wrap;
   logic dim_en;
   logic ms_en;
   logic [6:0] phase;
   modport gen(output step_en, wrap, dim_en, ms_en, phase);
   modport cons(input step_en, wrap, dim_en, ms_en, phase);
endinterface
`default_nettype wire

/* File: lbp_tick.sv */
// Purpose: Step clock enable, PWM phase counter and slow dimming and ramp enables.
// Assumes: One clock; slower rates are single-cycle enables.
// Notes: Wrap pulses in the first cycle of each new period.
`timescale 1ns/100ps
`default_nettype none
module lbp_tick #(
   parameter int DIM_CYCLES = lbp_pkg::DIM_CYCLES,
   parameter int RAMP_CYCLES = lbp_pkg::RAMP_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   lbp_timing_if.gen tm
);
   logic [lbp_pkg::DIV_W-1:0] div;
   logic [lbp_pkg::TICK_W-1:0] dim_cnt;
   logic [lbp_pkg::TICK_W-1:0] ms_cnt;
   logic div_end;

   assign div_end = (div == lbp_pkg::DIV_W'(lbp_pkg::STEP_DIV - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i || div_end) begin
         div <= '0;
      end else begin
         div <= div + lbp_pkg::DIV_W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tm.step_en <= 1'b0;
         tm.wrap <= 1'b0;
         tm.phase <= 7'h00;
      end else begin
         tm.step_en <= div_end;
         tm.wrap <= div_end && (tm.phase == lbp_pkg::PWM_LAST);
         if (div_end) begin
            tm.phase <= (tm.phase == lbp_pkg::PWM_LAST) ? 7'h00 : tm.phase + 7'h01;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || dim_cnt == lbp_pkg::TICK_W'(DIM_CYCLES - 1)) begin
         dim_cnt <= '0;
      end else begin
         dim_cnt <= dim_cnt + lbp_pkg::TICK_W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || ms_cnt == lbp_pkg::TICK_W'(RAMP_CYCLES - 1)) begin
         ms_cnt <= '0;
      end else begin
         ms_cnt <= ms_cnt + lbp_pkg::TICK_W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tm.dim_en <= 1'b0;
         tm.ms_en <= 1'b0;
      end else begin
         tm.dim_en <= (dim_cnt == lbp_pkg::TICK_W'(DIM_CYCLES - 1));
         tm.ms_en <= (ms_cnt == lbp_pkg::TICK_W'(RAMP_CYCLES - 1));
      end
   end

   // Helper counts cycles between period wraps.
   logic [9:0] gap;
   logic seen;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gap <= 10'h000;
         seen <= 1'b0;
      end else begin
         gap <= tm.wrap ? 10'h000 : gap + 10'h001;
         seen <= seen | tm.wrap;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_pwm_period: assert property (tm.wrap && seen |-> gap == 10'(lbp_pkg::PERIOD_CYCLES - 1))
      else $error("PWM period length wrong");
   c_period: cover property (tm.wrap && seen);
endmodule
`default_nettype wire

/* File: lbp_string.sv */
// Purpose: One string: PWM ratio dimming, current code ramping, period-aligned adoption.
// Assumes: Enables come from lbp_tick through the timing interface.
// Notes: ratio_o and code_o change only in a wrap cycle.
`timescale 1ns/100ps
`default_nettype none
module lbp_string (
   input wire logic clk_i,
   input wire logic rst_i,
   lbp_timing_if.cons tm,
   input wire logic [6:0] ratio_tgt_i,
   input wire logic dim_i,
   input wire logic [7:0] code_tgt_i,
   input wire logic ramp_i,
   input wire logic pwm_only_i,
   output logic [6:0] ratio_o,
   output logic [7:0] code_o
);
   logic [6:0] work_ratio;
   logic [7:0] work_code;
   logic [6:0] next_ratio;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         work_ratio <= 7'h00;
      end else if (!dim_i) begin
         work_ratio <= ratio_tgt_i;
      end else if (tm.dim_en && work_ratio < ratio_tgt_i) begin
         work_ratio <= work_ratio + 7'h01;
      end else if (tm.dim_en && work_ratio > ratio_tgt_i) begin
         work_ratio <= work_ratio - 7'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         work_code <= 8'h00;
      end else if (!ramp_i) begin
         work_code <= code_tgt_i;
      end else if (tm.ms_en && work_code < code_tgt_i) begin
         work_code <= work_code + 8'h01;
      end else if (tm.ms_en && work_code > code_tgt_i) begin
         work_code <= work_code - 8'h01;
      end
   end

   always_comb begin
      next_ratio = work_ratio;
      if (!pwm_only_i && work_ratio != 7'h00 && work_ratio < lbp_pkg::PWM_MIN_RATIO) begin
         next_ratio = lbp_pkg::PWM_MIN_RATIO;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ratio_o <= 7'h00;
         code_o <= 8'h00;
      end else if (tm.wrap) begin
         ratio_o <= next_ratio;
         code_o <= work_code;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_dim_one_step: assert property (dim_i && tm.dim_en && work_ratio != ratio_tgt_i |=>
      (work_ratio == $past(work_ratio) + 7'h01) || (work_ratio == $past(work_ratio) - 7'h01))
      else $error("Dimming did not move one step");
   a_dim_hold: assert property (dim_i && !tm.dim_en |=> $stable(work_ratio))
      else $error("Dimming moved between steps");
   a_ratio_instant: assert property (!dim_i |=> work_ratio == $past(ratio_tgt_i))
      else $error("Undimmed ratio not taken at once");
   a_ramp_one_step: assert property (ramp_i && tm.ms_en && work_code != code_tgt_i |=>
      (work_code == $past(work_code) + 8'h01) || (work_code == $past(work_code) - 8'h01))
      else $error("Ramp did not move one code");
   a_ramp_hold: assert property (ramp_i && !tm.ms_en |=> $stable(work_code))
      else $error("Ramp moved between steps");
   a_duty_floor: assert property (tm.wrap && !pwm_only_i |=>
      ratio_o == 7'h00 || ratio_o >= lbp_pkg::PWM_MIN_RATIO)
      else $error("Duty below floor in current mode");
   a_adopt_wrap: assert property (!tm.wrap |=> $stable(ratio_o) && $stable(code_o))
      else $error("Setting adopted outside period boundary");
   c_dim_done: cover property (dim_i && tm.dim_en ##1 work_ratio == ratio_tgt_i);
   c_ramp_done: cover property (ramp_i && tm.ms_en ##1 work_code == code_tgt_i);
endmodule
`default_nettype wire

/* File: lbp_boost_model.sv */
// Purpose: Behavioural boost converter and string load seen by the control block.
// Assumes: Fault detectors react at once to the boost state and the load.
// Notes: The bench commands the load current in milliamps.
`timescale 1ns/100ps
`default_nettype none
module lbp_boost_model (
   input wire logic boost_on_i,
   input wire logic limit_hi_i,
   input wire logic loaded_i,
   input wire logic [11:0] load_ma_i,
   output logic over_voltage_o,
   output logic over_current_o
);
   logic [11:0] limit_ma;
   assign limit_ma = limit_hi_i ? 12'h3E8 : 12'h2C6;
   assign over_voltage_o = boost_on_i & !loaded_i;
   assign over_current_o = boost_on_i & (load_ma_i > limit_ma);
endmodule
`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench for the backlight PWM and boost control block.
// Assumes: Dimming and ramp steps shortened to 1000 cycles.
// Notes: A watchdog ends a hang through the same closing task.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [9:0] adr = 10'h000;
   logic [31:0] dat_w = 32'h0, dat_o;
   logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, ov, oc, irq_n, boost_en, lim, rate, mode;
   logic [3:0] sel = 4'h0;
   logic [2:0] incl, sink_en, sw;
   logic [7:0] code1, code2, code3, q, on_code, off_code;
   logic [11:0] load_ma = 12'h000;
   int mismatches = 0, tests_run = 0, on, rep_bad;
   logic h [950];

   lbp_backlight #(.DIM_CYCLES(1000), .RAMP_CYCLES(1000)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat_w), .dat_o(dat_o), .we_i(we),
      .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .over_voltage_i(ov),
      .over_current_i(oc), .interrupt_out_n_o(irq_n), .boost_enable_o(boost_en),
      .string1_loop_include_o(incl[0]), .string2_loop_include_o(incl[1]),
      .string3_loop_include_o(incl[2]), .inductor_limit_select_o(lim),
      .switching_rate_select_o(rate), .current_drive_mode_o(mode),
      .sink1_enable_o(sink_en[0]), .sink2_enable_o(sink_en[1]), .sink3_enable_o(sink_en[2]),
      .string_switch_o(sw), .log_current_code1_o(code1), .log_current_code2_o(code2),
      .log_current_code3_o(code3));
   lbp_boost_model i_boost (.boost_on_i(boost_en), .limit_hi_i(lim),
      .loaded_i(|(incl & sink_en)), .load_ma_i(load_ma), .over_voltage_o(ov),
      .over_current_o(oc));

   initial begin
      forever #25 clk_i = ~clk_i;
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] d);
      @(posedge clk_i);
      adr <= {idx, 2'b00};
      dat_w <= {24'h000000, d};
      we <= w;
      sel <= 4'hF;
      cyc <= 1'b1;
      stb <= 1'b1;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // Counts high cycles over one period and compares the next period with it.
   task automatic measure(input int s);
      on = 0;
      rep_bad = 0;
      for (int i = 0; i < 1900; i++) begin
         @(negedge clk_i);
         if (i < 950) begin
            h[i] = sw[s];
            on += int'(sw[s]);
            if (sw[s] === 1'b1) on_code = code1;
            else off_code = code1;
         end else if (h[i-950] !== sw[s]) rep_bad++;
      end
   endtask

   task automatic t_reset();
      wb(8'h46, 1'b0, 8'h00);
      chk("boost reg", q, 8'h00);
      chk("irq_n", irq_n, 1'h1);
      chk("outputs", {boost_en, incl, lim, rate, sink_en, sw}, 12'h000);
      chk("reset codes", {mode, code1, code2, code3}, 25'h0000000);
   endtask

   task automatic t_bits();
      wb(8'h47, 1'b1, 8'hD5);
      wb(8'h46, 1'b1, 8'hBE);
      chk("loop incl", incl, 3'h7);
      chk("limit", lim, 1'h1);
      chk("rate", rate, 1'h1);
      wb(8'h46, 1'b0, 8'h00);
      chk("boost rb", q, 8'h3E);
      wb(8'h46, 1'b1, 8'h04);
      chk("lim rate incl", {lim, rate, incl}, 5'h02);
      wb(8'h46, 1'b1, 8'h0E);
      wb(8'h47, 1'b1, 8'hD1);
      chk("incl2 cleared", incl, 3'h5);
      wb(8'h47, 1'b1, 8'h95);
      chk("pwm only", {mode, sink_en[2], incl[2]}, 3'h4);
      wb(8'h46, 1'b0, 8'h00);
      chk("boost rb2", q, 8'h02);
   endtask

   task automatic t_fault();
      wb(8'h47, 1'b1, 8'hD5);
      load_ma <= 12'h320;
      wb(8'h46, 1'b1, 8'h13);
      tick(5);
      chk("no trip", {boost_en, irq_n}, 2'h3);
      wb(8'h46, 1'b1, 8'h03);
      tick(5);
      chk("oc trip", {boost_en, irq_n}, 2'h0);
      wb(8'h46, 1'b0, 8'h00);
      chk("flag", q, 8'h82);
      tick(3);
      chk("flag clear", irq_n, 1'h1);
      load_ma <= 12'h4B0;
      wb(8'h46, 1'b1, 8'h53);
      tick(5);
      chk("masked", {boost_en, irq_n}, 2'h1);
      wb(8'h46, 1'b0, 8'h00);
      chk("masked flag", q, 8'hD2);
      load_ma <= 12'h000;
      wb(8'h46, 1'b1, 8'h01);
      tick(5);
      chk("ov trip", boost_en, 1'h0);
      wb(8'h46, 1'b0, 8'h00);
      chk("ov flag", q, 8'h80);
   endtask

   task automatic t_pwm();
      logic [6:0] r [7] = '{7'h00, 7'h05, 7'h10, 7'h5F, 7'h60, 7'h7F, 7'h14};
      int e [7] = '{0, 160, 160, 950, 950, 950, 200};
      wb(8'h48, 1'b1, 8'h05);
      wb(8'h49, 1'b1, 8'hFF);
      for (int k = 0; k < 7; k++) begin
         wb(8'h4C, 1'b1, {1'b0, r[k]});
         tick(1900);
         measure(0);
         chk("high cycles", on, e[k]);
         chk("period repeat", rep_bad, 0);
      end
      chk("on code", on_code, 8'hFF);
      chk("idle code", off_code, 8'h05);
      chk("idle code 2 3", {code2, code3}, 16'h0505);
      wb(8'h47, 1'b1, 8'h95);
      wb(8'h4E, 1'b1, 8'h05);
      tick(1900);
      measure(2);
      chk("pwm only high", on, 50);
   endtask

   task automatic t_dim_ramp();
      wb(8'h47, 1'b1, 8'hD5);
      wb(8'h4C, 1'b1, 8'h9E);
      measure(0);
      chk("dim start", on < 211, 1'h1);
      tick(11000);
      measure(0);
      chk("dim done", on, 300);
      wb(8'h47, 1'b1, 8'hD7);
      wb(8'h49, 1'b1, 8'hEF);
      measure(0);
      chk("ramp start", on_code > 8'hEF, 1'h1);
      tick(17000);
      measure(0);
      chk("ramp done", on_code, 8'hEF);
   endtask

   task automatic close_out();
      if (mismatches == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #(100000 * 50);
      mismatches++;
      close_out();
   end

   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_bits();
      t_fault();
      t_pwm();
      t_dim_ramp();
      close_out();
   end
endmodule
`default_nettype wire
